// ---- bench/ext_pins.sv ----
`timescale 1ns/100ps
`default_nettype none
// Every pad has a pull-up, so a pad that nobody drives reads high.
module ext_pins (
  // Pad side of the block
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  // Far-side devices
  input  wire logic [15:0] drv_val,
  input  wire logic [15:0] drv_en,
  // Resolved pad level
  output var  logic [15:0] pin_in
);
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (drv_en[i] ? drv_val[i] : 1'b1);
    end
  end
endmodule
`default_nettype wire

// ---- bench/pinmux_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module pinmux_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // Pads
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] analog_route
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_reset_pads_off: assert property ($past(rst) |-> pin_oe == 16'h0000 && pin_out == 16'h0000)
    else $error("pads not released after reset");
  // Stable route only, so a route and a buffer changing on one edge are not flagged.
  a_analog_no_drive: assert property ($stable(analog_route) |-> (analog_route & pin_oe) == 16'h0000)
    else $error("analog pin has its output buffer on");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
    else $error("read data dropped");
  a_read_refused: assert property (rvalid |-> !arready && rdata[31:8] == 24'h000000)
    else $error("read address accepted or upper bits set");
  a_write_refused: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");

  c_slverr: cover property (bvalid && bresp == pinmux_pkg::RESP_SLVERR);
  c_pad_driven: cover property (pin_oe != 16'h0000);
  c_read_done: cover property (rvalid && rready);
endmodule

bind port_pin_function_select pinmux_sva chk (
  .clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .pin_out(pin_out), .pin_oe(pin_oe), .analog_route(analog_route)
);
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] exp;
  } row_s;

  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] pin_in, pin_out, pin_oe, serial_out, alt_out, analog_route, drv_val, drv_en;
  logic        lighting_bus_transmit, timer_out, lighting_bus_receive, ext_int_a, ext_int_b;
  int          fail_count, samples_checked, cycles;
  row_s        rows [5] = '{
    '{8'h04, 32'h000000FE, 8'h04, 32'h000000FE},
    '{8'h00, 32'h00000000, 8'h00, 32'h000000FE},
    '{8'h40, 32'h00000005, 8'h40, 32'h00000005},
    '{8'h44, 32'h00000003, 8'h44, 32'h00000003},
    '{8'h08, 32'h00000008, 8'h08, 32'h00000008}};

  port_pin_function_select uut (
    .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .serial_out(serial_out),
    .alt_out(alt_out), .lighting_bus_transmit(lighting_bus_transmit),
    .timer_out(timer_out), .lighting_bus_receive(lighting_bus_receive),
    .ext_int_a(ext_int_a), .ext_int_b(ext_int_b), .analog_route(analog_route));

  ext_pins far (.pin_out(pin_out), .pin_oe(pin_oe), .drv_val(drv_val), .drv_en(drv_en),
    .pin_in(pin_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // The master never assumes a latency; only the cycle ceiling ends a hang.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hF,
                    input logic [1:0] er = pinmux_pkg::RESP_OKAY);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    check(bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    input logic [1:0] er = pinmux_pkg::RESP_OKAY);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    v = rdata;
    check(rresp, er);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check(v, exp);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, timer_out} = '0;
    {awaddr, araddr, wdata, wstrb, alt_out, drv_val, drv_en} = '0;
    {fail_count, samples_checked, cycles} = '0;
    serial_out = 16'hFFFF;
    lighting_bus_transmit = 1'b1;
    rst = 1'b1;
    tick(10);
    rst <= 1'b0;
    tick(3);
    check(pin_oe, 16'h0000);
    check(analog_route, 16'h0500);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rc(rows[i].ra, rows[i].exp);
    end
    $display("register table test done");
    // A second reset in mid-run must undo everything written above.
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(3);
    check({pin_oe, pin_out}, 32'h00000000);
    rc(8'h04, 32'h000000FF);
    rc(8'h40, 32'h00000000);
    $display("reset test done");
    wr(8'h04, 32'h000000FE);
    wr(pinmux_pkg::ADDR_BITOP, 32'h00000010);
    rc(8'h00, 32'h000000FF);
    wr(8'h04, 32'h00000000);
    rc(8'h00, 32'h000000FF);
    wr(pinmux_pkg::ADDR_BITOP, 32'h00000113);
    rc(8'h10, 32'h000000FA);
    rd(pinmux_pkg::ADDR_BITOP, d, pinmux_pkg::RESP_SLVERR);
    wr(8'h00, 32'h00000001);
    tick(2);
    check(pin_out[7:0], 32'h01);
    wr(8'h00, 32'h000000FF, 4'hE);
    rc(8'h00, 32'h00000001);
    wr(8'h50, 32'h00000001, 4'hF, pinmux_pkg::RESP_SLVERR);
    rd(8'h50, d, pinmux_pkg::RESP_SLVERR);
    check(d, 32'h00000000);
    $display("bit operation test done");
    wr(8'h08, 32'h00000002);
    wr(8'h00, 32'h00000003);
    tick(2);
    check({pin_oe[1:0], pin_out[1:0]}, 32'h5);
    wr(8'h00, 32'h00000001);
    tick(2);
    check({pin_oe[1:0], pin_out[1:0]}, 32'hD);
    serial_out <= 16'hFFFE;
    tick(2);
    check(pin_out[0], 32'h0);
    alt_out <= 16'h0001;
    tick(2);
    check(pin_out[0], 32'h1);
    serial_out <= 16'hFFFF;
    alt_out <= 16'h0000;
    $display("pad drive test done");
    for (int v = 0; v < 16; v++) begin
      wr(pinmux_pkg::ADDR_ANALOG_PIN_CONFIG_FIELD, 32'(v));
      tick(2);
      check(analog_route[8], 32'(v != 1));
      check(analog_route[10], 32'(v == 0 || v > 3));
    end
    $display("analog select test done");
    wr(8'h08, 32'h00000000);
    for (int r = 0; r < 16; r += 15) begin
      wr(8'h04, 32'h00000000);
      wr(8'h14, 32'h00000000);
      wr(8'h10, 32'h00000020);
      wr(8'h40, 32'(r));
      timer_out <= 1'b1;
      lighting_bus_transmit <= 1'b0;
      tick(2);
      check({pin_out[0], pin_out[13], pin_out[2], pin_out[12]}, r ? 32'h6 : 32'h9);
      wr(8'h04, 32'h000000FF);
      wr(8'h14, 32'h000000FF);
      drv_val <= 16'h0802;
      drv_en <= 16'hFFFF;
      tick(4);
      check({lighting_bus_receive, ext_int_a, ext_int_b}, r ? 32'h6 : 32'h1);
      drv_en <= 16'h0000;
    end
    $display("redirection test done");
    test_done();
  end
endmodule
`default_nettype wire

// ---- common/pinmux_pkg.sv ----
`default_nettype none
package pinmux_pkg;

  // Geometry: two 8-bit ports, pins numbered port*8+bit.
  localparam int NPORTS = 2;
  localparam int PW     = 8;
  localparam int NPINS  = NPORTS * PW;

  // Register map, byte addresses.
  localparam logic [7:0] ADDR_PORT_STRIDE = 8'h10;
  localparam logic [3:0] OFF_DATA         = 4'h0;
  localparam logic [3:0] OFF_DIR          = 4'h4;
  localparam logic [3:0] OFF_ODS          = 4'h8;
  localparam logic [3:0] OFF_ADS          = 4'hC;
  localparam logic [7:0] ADDR_REDIRECT    = 8'h40;
  localparam logic [7:0] ADDR_ANALOG_PIN_CONFIG_FIELD        = 8'h44;
  localparam logic [7:0] ADDR_BITOP       = 8'h48;

  // Reset values.
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [7:0] DIR_RST   = 8'hFF;
  localparam logic [7:0] ODS_RST   = 8'h00;
  localparam logic [7:0] ADS_RST   = 8'h00;
  localparam logic [3:0] REDIR_RST = 4'h0;
  localparam logic [3:0] ANALOG_PIN_CONFIG_FIELD_RST  = 4'h0;

  // Analog pin configuration field decode.
  localparam logic [3:0] ANALOG_PIN_CONFIG_FIELD_ALL_DIGITAL = 4'h1;
  localparam logic [3:0] ANALOG_PIN_CONFIG_FIELD_AN2_DIG_HI  = 4'h3;
  localparam int         AN0_PIN          = 8;
  localparam int         AN2_PIN          = 10;

  // Redirection register bits.
  localparam int RDR_TIMER = 0;
  localparam int RDR_LBUS  = 1;
  localparam int RDR_INTA  = 2;
  localparam int RDR_INTB  = 3;

  // Pin locations: _SET when the redirect bit is 1, _CLR when it is 0.
  localparam int TMR_PIN_SET  = 2;
  localparam int TMR_PIN_CLR  = 12;
  localparam int LTX_PIN_SET  = 0;
  localparam int LTX_PIN_CLR  = 13;
  localparam int LRX_PIN_SET  = 1;
  localparam int LRX_PIN_CLR  = 14;
  localparam int INTA_PIN_SET = 11;
  localparam int INTA_PIN_CLR = 0;
  localparam int INTB_PIN_SET = 15;
  localparam int INTB_PIN_CLR = 1;

  // Bit-operation command fields.
  localparam int BITOP_BIT_LSB = 0;
  localparam int BITOP_VAL_BIT = 4;
  localparam int BITOP_PORT_BIT = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage
`default_nettype wire

// ---- common/reg_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface reg_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;

  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                input  wr_ok, rd_data, rd_ok);
  modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface
`default_nettype wire

// ---- design/axil_slave.sv ----
`timescale 1ns/100ps
`default_nettype none
module axil_slave (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Write address and data
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  // Write response
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  // Read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // Register side
  reg_if.bus               rif
);

  logic aw_hold;
  logic w_hold;
  logic next_aw_hold;
  logic next_w_hold;
  logic next_bvalid;
  logic next_rvalid;
  logic [7:0] aw_addr_q;

  // The commit waits until both halves are held, so either order works.
  assign rif.wr_en   = aw_hold & w_hold & ~bvalid;
  assign rif.wr_addr = aw_addr_q;
  assign rif.rd_addr = araddr;

  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold  = w_hold;
    next_bvalid  = bvalid;
    next_rvalid  = rvalid;
    if (awvalid && awready) begin
      next_aw_hold = 1'b1;
    end
    if (wvalid && wready) begin
      next_w_hold = 1'b1;
    end
    if (rif.wr_en) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      bvalid  <= 1'b0;
      rvalid  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      arready <= 1'b0;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold  <= next_w_hold;
      bvalid  <= next_bvalid;
      rvalid  <= next_rvalid;
      awready <= ~next_aw_hold & ~next_bvalid & ~(awvalid & awready);
      wready  <= ~next_w_hold & ~next_bvalid & ~(wvalid & wready);
      arready <= ~next_rvalid & ~(arvalid & arready);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_addr_q   <= 8'h00;
      rif.wr_data <= 32'h0000_0000;
      rif.wr_strb <= 4'h0;
      bresp       <= pinmux_pkg::RESP_OKAY;
      rdata       <= 32'h0000_0000;
      rresp       <= pinmux_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        rif.wr_data <= wdata;
        rif.wr_strb <= wstrb;
      end
      if (rif.wr_en) begin
        bresp <= rif.wr_ok ? pinmux_pkg::RESP_OKAY : pinmux_pkg::RESP_SLVERR;
      end
      if (arvalid && arready) begin
        rdata <= rif.rd_ok ? rif.rd_data : 32'h0000_0000;
        rresp <= rif.rd_ok ? pinmux_pkg::RESP_OKAY : pinmux_pkg::RESP_SLVERR;
      end
    end
  end

endmodule
`default_nettype wire

// ---- design/pin_cell.sv ----
`timescale 1ns/100ps
`default_nettype none
module pin_cell (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Port configuration
  input  wire logic [7:0] latch,
  input  wire logic [7:0] dir,
  input  wire logic [7:0] ods,
  input  wire logic [7:0] analog,
  // Alternate function outputs
  input  wire logic [7:0] sau_and,
  input  wire logic [7:0] alt_or,
  // Pad
  output var  logic [7:0] pin_out,
  output var  logic [7:0] pin_oe
);

  logic [7:0] level;
  logic [7:0] digital_out;

  assign level       = (latch & sau_and) | alt_or;  // R8
  assign digital_out = ~dir & ~analog;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= 8'h00;
      pin_oe  <= 8'h00;  // R9 R10
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (ods[i]) begin
          pin_out[i] <= 1'b0;
          pin_oe[i]  <= digital_out[i] & ~level[i];  // R4
        end else begin
          pin_out[i] <= level[i];
          pin_oe[i]  <= digital_out[i];  // R4
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- design/port_pin_function_select.sv ----
// Behaviour
// (R1) Data write loads output latch; read gives pin for inputs, latch for outputs.
// (R2) Single-bit set or clear reads whole port, changes one bit, writes byte back.
// (R3) Software rewrites a latch when switching a pin from input to output.
// (R4) Open-drain output pins drive low only; push-pull pins drive both levels.
// (R5) Third analog pin is digital only for field 01H to 03H.
// (R6) First analog pin is digital only when the field equals 01H.
// (R7) Redirect bits move lighting bus, timer output and two interrupts between pins.
// (R8) Pin level is latch AND serial output, OR other alternate outputs.
// (R9) Reset clears latches and sets every pin to input with buffer off.
// (R10) After reset every pin stays high impedance until its direction changes.
`timescale 1ns/100ps
`default_nettype none
module port_pin_function_select (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  // AXI4-Lite write response
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // Pads
  input  wire logic [15:0] pin_in,
  output var  logic [15:0] pin_out,
  output var  logic [15:0] pin_oe,
  // Peripheral outputs toward the pads
  input  wire logic [15:0] serial_out,
  input  wire logic [15:0] alt_out,
  input  wire logic        lighting_bus_transmit,
  input  wire logic        timer_out,
  // Peripheral inputs from the pads
  output var  logic        lighting_bus_receive,
  output var  logic        ext_int_a,
  output var  logic        ext_int_b,
  output var  logic [15:0] analog_route
);

  localparam int NP = pinmux_pkg::NPORTS;
  localparam int W  = pinmux_pkg::PW;
  localparam int NI = pinmux_pkg::NPINS;

  reg_if rif ();

  // Per-port register state; pin_sync is the only view of the pads.
  logic [W-1:0] latch [NP];
  logic [W-1:0] dir   [NP];
  logic [W-1:0] ods   [NP];
  logic [W-1:0] ads   [NP];
  logic [3:0]   redirect;
  logic [3:0]   analog_pin_config_field;
  logic [NI-1:0] pin_meta;
  logic [NI-1:0] pin_sync;
  logic [NI-1:0] analog;
  logic [NI-1:0] sau_and;
  logic [NI-1:0] alt_or;

  // Port field of an address, and whether the address hits a port register.
  function automatic logic port_hit(input logic [7:0] addr);
    port_hit = (addr[7:4] < 4'(NP)) && (addr[1:0] == 2'b00);
  endfunction

  // Port number carried in the upper address nibble.
  function automatic int port_of(input logic [7:0] addr);
    port_of = int'(addr[7:4]);
  endfunction

  // Byte that software sees on a port data read.
  // Bit operations use the same view, so input pins copy their level into the latch.
  function automatic logic [W-1:0] port_view(input logic [W-1:0] lat,
                                              input logic [W-1:0] d,
                                              input logic [W-1:0] pins,
                                              input logic [W-1:0] an);
    port_view = ((d & pins) | (~d & lat)) & ~an;  // R1
  endfunction

  // The front end answers a read one edge after it is taken, a write two edges later.
  axil_slave u_bus (
    .clk     (clk),
    .rst     (rst),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rif     (rif.bus)
  );

  // Pads are asynchronous to clk; only pin_sync is ever read.
  // A pad change therefore reaches a data read two edges late.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta <= 16'h0000;
      pin_sync <= 16'h0000;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Analog selection: per-pin select bits plus the two field-decoded pins.
  // The field only adds analog pins; a select bit alone can still make a pin analog.
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      analog[p*W +: W] = ads[p];
    end
    if (analog_pin_config_field != pinmux_pkg::ANALOG_PIN_CONFIG_FIELD_ALL_DIGITAL) begin
      analog[pinmux_pkg::AN0_PIN] = 1'b1;  // R6
    end
    if (analog_pin_config_field < pinmux_pkg::ANALOG_PIN_CONFIG_FIELD_ALL_DIGITAL || analog_pin_config_field > pinmux_pkg::ANALOG_PIN_CONFIG_FIELD_AN2_DIG_HI) begin
      analog[pinmux_pkg::AN2_PIN] = 1'b1;  // R5
    end
  end

  // Serial outputs idle high into the AND, other outputs idle low into the OR.
  // Redirection gates a peripheral onto one of its two pins; the other keeps its own.
  always_comb begin
    sau_and = serial_out;
    alt_or  = alt_out;
    if (redirect[pinmux_pkg::RDR_LBUS]) begin
      sau_and[pinmux_pkg::LTX_PIN_SET] = serial_out[pinmux_pkg::LTX_PIN_SET]
                                         & lighting_bus_transmit;  // R7 R8
    end else begin
      sau_and[pinmux_pkg::LTX_PIN_CLR] = serial_out[pinmux_pkg::LTX_PIN_CLR]
                                         & lighting_bus_transmit;  // R7 R8
    end
    if (redirect[pinmux_pkg::RDR_TIMER]) begin
      alt_or[pinmux_pkg::TMR_PIN_SET] = alt_out[pinmux_pkg::TMR_PIN_SET] | timer_out;  // R7
    end else begin
      alt_or[pinmux_pkg::TMR_PIN_CLR] = alt_out[pinmux_pkg::TMR_PIN_CLR] | timer_out;  // R7
    end
  end

  // Inputs routed from whichever location the redirect bit selects.
  always_ff @(posedge clk) begin
    if (rst) begin
      lighting_bus_receive <= 1'b0;
      ext_int_a            <= 1'b0;
      ext_int_b            <= 1'b0;
      analog_route         <= 16'h0000;
    end else begin
      lighting_bus_receive <= redirect[pinmux_pkg::RDR_LBUS]
                              ? pin_sync[pinmux_pkg::LRX_PIN_SET]
                              : pin_sync[pinmux_pkg::LRX_PIN_CLR];  // R7
      ext_int_a <= redirect[pinmux_pkg::RDR_INTA]
                   ? pin_sync[pinmux_pkg::INTA_PIN_SET]
                   : pin_sync[pinmux_pkg::INTA_PIN_CLR];  // R7
      ext_int_b <= redirect[pinmux_pkg::RDR_INTB]
                   ? pin_sync[pinmux_pkg::INTB_PIN_SET]
                   : pin_sync[pinmux_pkg::INTB_PIN_CLR];  // R7
      analog_route <= analog;  // R5 R6
    end
  end

  // Register reads. Analog pins read as zero, since their digital input is cut off.
  // Upper data bits always read zero because no register is wider than one byte.
  always_comb begin
    logic [7:0] a;
    int         p;
    a           = rif.rd_addr;
    p           = port_of(a);
    rif.rd_data = 32'h0000_0000;
    rif.rd_ok   = 1'b1;
    if (port_hit(a)) begin
      case (a[3:0])
        pinmux_pkg::OFF_DATA: rif.rd_data[W-1:0] = port_view(latch[p], dir[p],
                                pin_sync[p*W +: W], analog[p*W +: W]);  // R1
        pinmux_pkg::OFF_DIR: rif.rd_data[W-1:0] = dir[p];
        pinmux_pkg::OFF_ODS: rif.rd_data[W-1:0] = ods[p];
        pinmux_pkg::OFF_ADS: rif.rd_data[W-1:0] = ads[p];
        default: rif.rd_ok = 1'b0;
      endcase
    end else if (a == pinmux_pkg::ADDR_REDIRECT) begin
      rif.rd_data[3:0] = redirect;
    end else if (a == pinmux_pkg::ADDR_ANALOG_PIN_CONFIG_FIELD) begin
      rif.rd_data[3:0] = analog_pin_config_field;
    end else begin
      rif.rd_ok = 1'b0;
    end
  end

  // Unmapped writes are answered with an error and change nothing.
  always_comb begin
    rif.wr_ok = port_hit(rif.wr_addr)
                || rif.wr_addr == pinmux_pkg::ADDR_REDIRECT
                || rif.wr_addr == pinmux_pkg::ADDR_ANALOG_PIN_CONFIG_FIELD
                || rif.wr_addr == pinmux_pkg::ADDR_BITOP;
  end

  // Output latches: byte writes and bit operations. A bit operation writes
  // back pin levels of input bits too, which is why software must reload a
  // latch before turning its pin into an output.
  always_ff @(posedge clk) begin
    logic [7:0]   a;
    int           p;
    int           b;
    logic [W-1:0] view;
    a    = rif.wr_addr;
    p    = port_of(a);
    b    = int'(rif.wr_data[pinmux_pkg::BITOP_BIT_LSB +: 3]);
    view = '0;
    if (rst) begin
      for (int i = 0; i < NP; i++) begin
        latch[i] <= pinmux_pkg::DATA_RST;  // R9
      end
    end else if (rif.wr_en && rif.wr_strb[0]) begin
      if (port_hit(a) && a[3:0] == pinmux_pkg::OFF_DATA) begin
        latch[p] <= rif.wr_data[W-1:0];  // R1
      end else if (a == pinmux_pkg::ADDR_BITOP) begin
        p    = int'(rif.wr_data[pinmux_pkg::BITOP_PORT_BIT]);
        view = port_view(latch[p], dir[p], pin_sync[p*W +: W], analog[p*W +: W]);  // R2
        view[b] = rif.wr_data[pinmux_pkg::BITOP_VAL_BIT];  // R2
        latch[p] <= view;  // R2 R3
      end
    end
  end

  // Direction, open-drain and analog select bits.
  // Only byte lane zero carries these registers, so other strobes are ignored.
  always_ff @(posedge clk) begin
    logic [7:0] a;
    int         p;
    a = rif.wr_addr;
    p = port_of(a);
    if (rst) begin
      for (int i = 0; i < NP; i++) begin
        dir[i] <= pinmux_pkg::DIR_RST;  // R9 R10
        ods[i] <= pinmux_pkg::ODS_RST;
        ads[i] <= pinmux_pkg::ADS_RST;
      end
    end else if (rif.wr_en && rif.wr_strb[0] && port_hit(a)) begin
      case (a[3:0])
        pinmux_pkg::OFF_DIR: dir[p] <= rif.wr_data[W-1:0];
        pinmux_pkg::OFF_ODS: ods[p] <= rif.wr_data[W-1:0];
        pinmux_pkg::OFF_ADS: ads[p] <= rif.wr_data[W-1:0];
        default: ;
      endcase
    end
  end

  // Redirect and analog pin configuration.
  // Moving a signal hands its old pin back to the port latch at once, so
  // software should park that pin first if a glitch there matters.
  always_ff @(posedge clk) begin
    if (rst) begin
      redirect <= pinmux_pkg::REDIR_RST;
      analog_pin_config_field     <= pinmux_pkg::ANALOG_PIN_CONFIG_FIELD_RST;
    end else if (rif.wr_en && rif.wr_strb[0]) begin
      if (rif.wr_addr == pinmux_pkg::ADDR_REDIRECT) begin
        redirect <= rif.wr_data[3:0];  // R7
      end
      if (rif.wr_addr == pinmux_pkg::ADDR_ANALOG_PIN_CONFIG_FIELD) begin
        analog_pin_config_field <= rif.wr_data[3:0];
      end
    end
  end

  // One pad cell per port; each registers its drive so the pads see no decode glitches.
  for (genvar g = 0; g < NP; g++) begin : g_port
    pin_cell u_cell (
      .clk     (clk),
      .rst     (rst),
      .latch   (latch[g]),
      .dir     (dir[g]),
      .ods     (ods[g]),
      .analog  (analog[g*W +: W]),
      .sau_and (sau_and[g*W +: W]),
      .alt_or  (alt_or[g*W +: W]),
      .pin_out (pin_out[g*W +: W]),
      .pin_oe  (pin_oe[g*W +: W])
    );
  end

endmodule
`default_nettype wire
